// File: pkg/gst_pkg.sv
// shared constants and types for the gated sixteen-bit timer
package gst_pkg;

    // ==========================================================
    // register map (byte-wide registers on a 3-bit address)
    localparam logic [2:0] GST_ADDR_COUNT_LOW = 3'h0;
    localparam logic [2:0] GST_ADDR_COUNT_HIGH = 3'h1;
    localparam logic [2:0] GST_ADDR_TIMER_CONTROL = 3'h2;
    localparam logic [2:0] GST_ADDR_GATE_CONTROL = 3'h3;
    localparam logic [2:0] GST_ADDR_CCP_LOW = 3'h4;
    localparam logic [2:0] GST_ADDR_CCP_HIGH = 3'h5;
    localparam logic [2:0] GST_ADDR_CCP_CONTROL = 3'h6;
    localparam logic [2:0] GST_ADDR_FLAGS = 3'h7;

    // ==========================================================
    // field positions of the flag and capture/compare registers
    localparam int GST_FLAG_OVERFLOW = 0;
    localparam int GST_FLAG_GATE_EVENT = 1;
    localparam int GST_FLAG_CCP = 2;
    localparam int GST_CCP_CAPTURE = 0;
    localparam int GST_CCP_COMPARE = 1;
    localparam int GST_CCP_TRIGGER = 2;

    // ==========================================================
    // reset values and counts
    localparam logic [7:0] GST_RST_BYTE = 8'h00;
    localparam logic [15:0] GST_RST_COUNT = 16'h0000;
    localparam logic [15:0] GST_COUNT_MAX = 16'hFFFF;
    localparam logic [1:0] GST_INSTR_DIV_LAST = 2'h3;

    // ==========================================================
    // encodings
    typedef enum logic [1:0] {GST_CS_INSTR, GST_CS_SYS, GST_CS_PIN, GST_CS_SENSE} gst_cs_e;
    typedef enum logic [1:0] {GST_GS_PIN, GST_GS_T0, GST_GS_CMPA, GST_GS_CMPB} gst_gs_e;
    typedef enum {GST_SP_IDLE, GST_SP_WAIT, GST_SP_PULSE} gst_sp_e;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } gst_bus_s;

    typedef struct packed {
        gst_cs_e clock_source_select;
        logic [1:0] prescale_select;
        logic dedicated_osc_enable;
        logic sync_disable;
        logic counter_on;
    } gst_tctl_s;

    typedef struct packed {
        logic gate_enable;
        logic gate_polarity;
        logic gate_toggle_mode;
        logic gate_single_pulse_mode;
        gst_gs_e gate_source_select;
    } gst_gctl_s;

    typedef struct packed {
        logic external_clock_pin;
        logic crystal_in_pin;
        logic sensing_oscillator;
    } gst_clk_pins_s;

    typedef struct packed {
        logic gate_pin;
        logic companion_overflow;
        logic comparator_a_output;
        logic comparator_b_output;
    } gst_gate_pins_s;

endpackage

// File: hw/gst_timer.sv
// gated sixteen-bit timer with capture/compare time base
`timescale 1ns/1ps

// Operation
// [RL1] capture event copies full counter into capture/compare pair
// [RL2] compare match of pair and counter raises an event, optionally a trigger
// [RL3] special event trigger clears the counter to zero
// [RL4] trigger clear never sets the overflow flag
// [RL5] software should use synchronized instruction clock with triggers
// [RL6] a counter byte write beats a coincident trigger clear
// [RL7] source field picks instruction, system, pin/crystal or sensing clock
// [RL8] pin source uses external pin or crystal by oscillator enable
// [RL9] prescale field divides by 1, 2, 4 or 8
// [RL10] sync bit chooses synchronized or raw path for outside clocks
// [RL11] on bit enables counting; off stops it and clears toggle flop
// [RL12] gate enable applies only while on; else count freely
// [RL13] polarity picks counting on high or low gate
// [RL14] toggle mode passes gate through toggle flop, else flop held clear
// [RL15] single-pulse mode puts gate under single-pulse logic
// [RL16] go/done reads 1 while armed, hardware clears it
// [RL17] gate value bit shows current gate regardless of gate enable
// [RL18] gate source picks pin, companion overflow, comparator a or b
// [RL19] writable bits zero at power-on reset, kept otherwise
// [RL20] go/done clears at trailing edge of captured pulse
// [RL21] falling gate value sets gate event flag
// [RL22] counter rolls FFFF to 0000 and sets overflow flag
// [RL23] companion overflow becomes one low-to-high gate pulse
// [RL24] counter steps on prescaled tick while on and gate permits
// [RL25] counter accessed as separate high and low bytes
module gst_timer import gst_pkg::*; (
    // clock, reset, enable
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // register port
    input wire gst_bus_s bus_req,
    output logic [7:0] rd_data,
    // clock and gate sources
    input wire gst_clk_pins_s clk_pins,
    input wire gst_gate_pins_s gate_pins,
    // capture/compare unit events
    input wire logic capture_event,
    input wire logic special_event_in,
    output logic compare_event,
    // sticky flags
    output logic overflow_flag,
    output logic gate_event_flag,
    output logic ccp_flag
);

    // ==========================================================
    // state
    gst_tctl_s tctl;
    gst_gctl_s gctl;
    gst_sp_e sp_state;
    logic [15:0] count;
    logic [15:0] ccp_val;
    logic [2:0] ccp_ctl;
    logic [1:0] instr_div;
    logic [2:0] pre_cnt;
    logic [2:0] pin_q, pin_qq, sy1, sy2, sy3;
    logic t0_pulse, gact_q, tog, tg_q, gval, match_q;

    // ==========================================================
    // decode
    logic wr_low, wr_high, wr_tctl, wr_gctl, wr_flags, cnt_wr;
    assign wr_low = bus_req.wr && bus_req.addr == GST_ADDR_COUNT_LOW;
    assign wr_high = bus_req.wr && bus_req.addr == GST_ADDR_COUNT_HIGH;
    assign wr_tctl = bus_req.wr && bus_req.addr == GST_ADDR_TIMER_CONTROL;
    assign wr_gctl = bus_req.wr && bus_req.addr == GST_ADDR_GATE_CONTROL;
    assign wr_flags = bus_req.wr && bus_req.addr == GST_ADDR_FLAGS;
    assign cnt_wr = wr_low || wr_high;

    // ==========================================================
    // control registers; sys_rst is the power-on reset, nothing else clears
    // [RL19] zero at power-on
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tctl <= gst_tctl_s'(GST_RST_BYTE[6:0]);
            gctl <= gst_gctl_s'(6'h00);
            ccp_ctl <= 3'h0;
        end else if (clk_en) begin
            if (wr_tctl) begin
                tctl <= {bus_req.wdata[7:2], bus_req.wdata[0]};
            end
            if (wr_gctl) begin
                gctl <= {bus_req.wdata[7:4], bus_req.wdata[1:0]};
            end
            if (bus_req.wr && bus_req.addr == GST_ADDR_CCP_CONTROL) begin
                ccp_ctl <= bus_req.wdata[2:0];
            end
        end
    end

    // ==========================================================
    // clock source paths
    logic [2:0] pin_edge;
    logic src_tick, pre_tick, inc;
    logic [2:0] pre_mask;

    // [RL10] raw or two-flop synchronized edge detect
    assign pin_edge = tctl.sync_disable ? (pin_q & ~pin_qq) : (sy2 & ~sy3);

    // sy1 feeds only sy2; edges come from later stages
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            {pin_q, pin_qq, sy1, sy2, sy3} <= 15'h0000;
            instr_div <= 2'h0;
        end else if (clk_en) begin
            pin_q <= clk_pins;
            pin_qq <= pin_q;
            sy1 <= clk_pins;
            sy2 <= sy1;
            sy3 <= sy2;
            instr_div <= instr_div + 2'h1;
        end
    end

    // [RL7] source select
    always_comb begin
        case (tctl.clock_source_select)
            GST_CS_INSTR: src_tick = instr_div == GST_INSTR_DIV_LAST;
            GST_CS_SYS: src_tick = 1'b1;
            // [RL8] pin or crystal
            GST_CS_PIN: src_tick = tctl.dedicated_osc_enable ? pin_edge[1] : pin_edge[2];
            GST_CS_SENSE: src_tick = pin_edge[0];
            default: src_tick = 1'b0;
        endcase
    end

    // [RL9] prescaler passes every 2**n-th source tick
    assign pre_mask = 3'((4'h1 << tctl.prescale_select) - 4'h1);
    assign pre_tick = src_tick && (pre_cnt & pre_mask) == pre_mask;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pre_cnt <= 3'h0;
        end else if (clk_en) begin
            if (!tctl.counter_on) begin
                pre_cnt <= 3'h0;
            end else if (src_tick) begin
                pre_cnt <= pre_cnt + 3'h1;
            end
        end
    end

    // ==========================================================
    // gate path
    logic gsrc, gact, tg, tg_rise, tg_fall, next_gval;

    // [RL18] gate source mux
    always_comb begin
        case (gctl.gate_source_select)
            GST_GS_PIN: gsrc = gate_pins.gate_pin;
            GST_GS_T0: gsrc = t0_pulse;
            GST_GS_CMPA: gsrc = gate_pins.comparator_a_output;
            GST_GS_CMPB: gsrc = gate_pins.comparator_b_output;
            default: gsrc = 1'b0;
        endcase
    end

    // [RL13] active level follows polarity
    assign gact = gctl.gate_polarity ? gsrc : ~gsrc;
    // [RL14] toggled or direct
    assign tg = gctl.gate_toggle_mode ? tog : gact;
    assign tg_rise = tg && !tg_q;
    assign tg_fall = !tg && tg_q;

    // [RL23] companion overflow registered once: same width, one cycle late
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            t0_pulse <= 1'b0;
            gact_q <= 1'b0;
            tg_q <= 1'b0;
        end else if (clk_en) begin
            t0_pulse <= gate_pins.companion_overflow;
            gact_q <= gact;
            tg_q <= tg;
        end
    end

    // [RL14] toggle flop, held clear when mode off
    // [RL11] also cleared while counter off
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tog <= 1'b0;
        end else if (clk_en) begin
            if (!gctl.gate_toggle_mode || !tctl.counter_on) begin
                tog <= 1'b0;
            end else if (gact && !gact_q) begin
                tog <= ~tog;
            end
        end
    end

    // [RL15] single-pulse acquisition; writing go while mode off is ignored
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sp_state <= GST_SP_IDLE;
        end else if (clk_en) begin
            if (!gctl.gate_single_pulse_mode) begin
                sp_state <= GST_SP_IDLE;
            end else if (wr_gctl && !bus_req.wdata[3]) begin
                sp_state <= GST_SP_IDLE;
            end else begin
                case (sp_state)
                    GST_SP_IDLE: begin
                        if (wr_gctl && bus_req.wdata[3]) begin
                            sp_state <= GST_SP_WAIT;
                        end
                    end
                    GST_SP_WAIT: begin
                        if (tg_rise) begin
                            sp_state <= GST_SP_PULSE;
                        end
                    end
                    // [RL20] trailing edge ends acquisition
                    GST_SP_PULSE: begin
                        if (tg_fall) begin
                            sp_state <= GST_SP_IDLE;
                        end
                    end
                    default: sp_state <= GST_SP_IDLE;
                endcase
            end
        end
    end

    // [RL17] gate value independent of gate enable
    assign next_gval = gctl.gate_single_pulse_mode ? (sp_state == GST_SP_PULSE && tg) : tg;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            gval <= 1'b0;
        end else if (clk_en) begin
            gval <= next_gval;
        end
    end

    // ==========================================================
    // counter and capture/compare
    logic match, match_rise, clr, ovf;

    // [RL24] step on prescaled tick when on and gate allows
    // [RL12] gate enable only matters while on
    assign inc = tctl.counter_on && pre_tick && (!gctl.gate_enable || gval);
    assign match = ccp_val == count;
    assign match_rise = ccp_ctl[GST_CCP_COMPARE] && match && !match_q;
    // [RL3] any unit's trigger, or our own compare with the trigger bit set, clears the count
    // [RL5] unsynchronized sources may let the trigger slip past a tick
    assign clr = special_event_in || (match_rise && ccp_ctl[GST_CCP_TRIGGER]);
    // [RL22] rollover
    assign ovf = inc && count == GST_COUNT_MAX && !cnt_wr && !clr;

    // [RL6] writes first, then trigger clear, then increment
    // [RL25] byte-wise access
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            count <= GST_RST_COUNT;
        end else if (clk_en) begin
            if (cnt_wr) begin
                if (wr_low) begin
                    count[7:0] <= bus_req.wdata;
                end
                if (wr_high) begin
                    count[15:8] <= bus_req.wdata;
                end
            end else if (clr) begin
                count <= GST_RST_COUNT;
            end else if (inc) begin
                count <= count + 16'h0001;
            end
        end
    end

    // [RL1] capture copies the whole counter in one edge
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ccp_val <= GST_RST_COUNT;
        end else if (clk_en) begin
            if (bus_req.wr && bus_req.addr == GST_ADDR_CCP_LOW) begin
                ccp_val[7:0] <= bus_req.wdata;
            end else if (bus_req.wr && bus_req.addr == GST_ADDR_CCP_HIGH) begin
                ccp_val[15:8] <= bus_req.wdata;
            end else if (ccp_ctl[GST_CCP_CAPTURE] && capture_event) begin
                ccp_val <= count;
            end
        end
    end

    // [RL2] one event per match, not per cycle the match holds
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            match_q <= 1'b0;
            compare_event <= 1'b0;
        end else if (clk_en) begin
            match_q <= match;
            compare_event <= match_rise;
        end
    end

    // ==========================================================
    // sticky flags: write one to clear, a same-cycle set wins
    logic [2:0] flag_set, flag_clr;
    assign flag_clr = wr_flags ? bus_req.wdata[2:0] : 3'h0;
    // [RL4] trigger clear takes the ovf path away
    // [RL21] falling gate value
    assign flag_set = {match_rise || (ccp_ctl[GST_CCP_CAPTURE] && capture_event),
                       gval && !next_gval, ovf};

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            {ccp_flag, gate_event_flag, overflow_flag} <= 3'h0;
        end else if (clk_en) begin
            overflow_flag <= flag_set[GST_FLAG_OVERFLOW]
                || (overflow_flag && !flag_clr[GST_FLAG_OVERFLOW]);
            gate_event_flag <= flag_set[GST_FLAG_GATE_EVENT]
                || (gate_event_flag && !flag_clr[GST_FLAG_GATE_EVENT]);
            ccp_flag <= flag_set[GST_FLAG_CCP] || (ccp_flag && !flag_clr[GST_FLAG_CCP]);
        end
    end

    // ==========================================================
    // read port, data valid the cycle after the strobe
    logic [7:0] next_rd;
    always_comb begin
        case (bus_req.addr)
            GST_ADDR_COUNT_LOW: next_rd = count[7:0];
            GST_ADDR_COUNT_HIGH: next_rd = count[15:8];
            GST_ADDR_TIMER_CONTROL: next_rd = {tctl[6:1], 1'b0, tctl[0]};
            // [RL16] go/done shows armed state
            GST_ADDR_GATE_CONTROL: next_rd = {gctl[5:2], sp_state != GST_SP_IDLE, gval, gctl[1:0]};
            GST_ADDR_CCP_LOW: next_rd = ccp_val[7:0];
            GST_ADDR_CCP_HIGH: next_rd = ccp_val[15:8];
            GST_ADDR_CCP_CONTROL: next_rd = {5'h00, ccp_ctl};
            GST_ADDR_FLAGS: next_rd = {5'h00, ccp_flag, gate_event_flag, overflow_flag};
            default: next_rd = GST_RST_BYTE;
        endcase
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_data <= GST_RST_BYTE;
        end else if (clk_en) begin
            rd_data <= bus_req.rd ? next_rd : GST_RST_BYTE;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    sequence s_pulse_end;
        clk_en && gctl.gate_single_pulse_mode && sp_state == GST_SP_PULSE && tg_fall;
    endsequence

    a_count_step: assert property (clk_en && inc && !cnt_wr && !clr // [RL24]
        |=> count == $past(count) + 16'h0001) else $error("counter missed a step");
    a_trigger_clear: assert property (clk_en && clr && !cnt_wr |=> count == 16'h0000) // [RL3]
        else $error("trigger did not clear counter");
    a_write_wins: assert property (clk_en && clr && wr_low // [RL6]
        |=> count[7:0] == $past(bus_req.wdata)) else $error("trigger beat a write");
    a_rollover_flag: assert property (clk_en && ovf |=> overflow_flag && count == 16'h0000) // [RL22]
        else $error("rollover not flagged");
    a_trigger_no_ovf: assert property (clk_en && clr && !overflow_flag // [RL4]
        |=> !overflow_flag) else $error("trigger set overflow flag");
    a_capture_copy: assert property (clk_en && ccp_ctl[GST_CCP_CAPTURE] && capture_event // [RL1]
        && !bus_req.wr |=> ccp_val == $past(count)) else $error("capture lost counter value");
    a_compare_event: assert property (clk_en && match_rise // [RL2]
        |=> compare_event && ccp_flag) else $error("compare match not raised");
    a_off_holds: assert property (clk_en && !tctl.counter_on && !cnt_wr && !clr // [RL11]
        |=> count == $past(count) && !tog) else $error("stopped counter moved");
    a_gate_fall: assert property (clk_en && gval && !next_gval // [RL21]
        |=> gate_event_flag) else $error("gate fall not flagged");
    a_pulse_done: assert property (s_pulse_end |=> sp_state == GST_SP_IDLE // [RL20]
        ##0 rd_data[3] == 1'b0 || !$past(bus_req.rd)) else $error("go/done stuck after pulse");

endmodule

// File: verification/gst_far_side.sv
// far-side model: clock pins, gate sources and companion timer wrap
`timescale 1ns/1ps
module gst_far_side import gst_pkg::*; (
    // clock
    input wire logic sys_clk,
    // bench controls
    input wire logic clk_run,
    input wire logic [2:0] gate_lvl,
    input wire logic wrap_pulse,
    // toward the timer
    output gst_clk_pins_s clk_pins,
    output gst_gate_pins_s gate_pins
);
    // ==========================================================
    // clock sources
    logic [4:0] phase = 5'h00;
    // divider advances only in a burst, so the pins stand still between bursts
    always_ff @(posedge sys_clk) begin
        if (clk_run) begin
            phase <= phase + 5'h01;
        end
    end
    // distinct rates, so a wrong source pick shows as a wrong count
    assign clk_pins.external_clock_pin = phase[2];
    assign clk_pins.crystal_in_pin = phase[3];
    assign clk_pins.sensing_oscillator = phase[4];
    // ==========================================================
    // gate sources
    assign gate_pins.gate_pin = gate_lvl[0];
    assign gate_pins.comparator_a_output = gate_lvl[1];
    assign gate_pins.comparator_b_output = gate_lvl[2];
    // one-cycle wrap pulse of the companion timer
    assign gate_pins.companion_overflow = wrap_pulse;
endmodule

// File: verification/gated_sixteen_bit_timer_tb.sv
// self-checking bench for the gated sixteen-bit timer
`timescale 1ns/1ps
module gated_sixteen_bit_timer_tb import gst_pkg::*;;
    // ==========================================================
    // signals
    localparam logic [2:0] A_LO = GST_ADDR_COUNT_LOW;
    localparam logic [2:0] A_HI = GST_ADDR_COUNT_HIGH;
    localparam logic [2:0] A_TC = GST_ADDR_TIMER_CONTROL;
    localparam logic [2:0] A_GC = GST_ADDR_GATE_CONTROL;
    localparam logic [2:0] A_FL = GST_ADDR_FLAGS;
    typedef struct packed {logic [7:0] tc; logic [7:0] gc; logic [2:0] lvl; logic [7:0] d;} gst_row_s;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    gst_bus_s bus_req = '0;
    logic [7:0] rd_data;
    gst_clk_pins_s clk_pins;
    gst_gate_pins_s gate_pins;
    logic capture_event = 1'b0;
    logic special_event_in = 1'b0;
    logic compare_event, overflow_flag, gate_event_flag, ccp_flag;
    logic clk_run = 1'b0;
    logic clk_en = 1'b1;
    logic [2:0] gate_lvl = 3'h0;
    logic wrap_pulse = 1'b0;
    logic [7:0] v0, v1;
    logic found;
    int err_count = 0;
    int checked = 0;
    // rows: timer control, gate control, gate levels, count gained in 64 cycles
    gst_row_s rows [17] = '{
        '{8'h01, 8'h00, 3'h0, 8'h10}, '{8'h11, 8'h00, 3'h0, 8'h08}, '{8'h21, 8'h00, 3'h0, 8'h04},
        '{8'h31, 8'h00, 3'h0, 8'h02}, '{8'h41, 8'h00, 3'h0, 8'h40}, '{8'h71, 8'h00, 3'h0, 8'h08},
        '{8'h81, 8'h00, 3'h0, 8'h08}, '{8'h85, 8'h00, 3'h0, 8'h08}, '{8'h89, 8'h00, 3'h0, 8'h04},
        '{8'hC1, 8'h00, 3'h0, 8'h02}, '{8'h40, 8'h00, 3'h0, 8'h00}, '{8'h41, 8'hC0, 3'h1, 8'h40},
        '{8'h41, 8'hC0, 3'h0, 8'h00}, '{8'h41, 8'h80, 3'h0, 8'h40}, '{8'h41, 8'hC2, 3'h2, 8'h40},
        '{8'h41, 8'hC2, 3'h1, 8'h00}, '{8'h41, 8'hC3, 3'h4, 8'h40}};

    // 25 ns clock
    always #12.5 sys_clk = ~sys_clk;

    // ==========================================================
    // instances
    gst_timer u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en), .bus_req(bus_req),
        .rd_data(rd_data), .clk_pins(clk_pins), .gate_pins(gate_pins),
        .capture_event(capture_event), .special_event_in(special_event_in),
        .compare_event(compare_event), .overflow_flag(overflow_flag),
        .gate_event_flag(gate_event_flag), .ccp_flag(ccp_flag));
    gst_far_side u_far (.sys_clk(sys_clk), .clk_run(clk_run), .gate_lvl(gate_lvl),
        .wrap_pulse(wrap_pulse), .clk_pins(clk_pins), .gate_pins(gate_pins));

    // ==========================================================
    // tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        bus_req <= '{a, d, 1'b1, 1'b0};
        @(posedge sys_clk);
        bus_req.wr <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe, so sample it there
    task automatic bus_rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        bus_req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge sys_clk);
        bus_req.rd <= 1'b0;
        #1;
        d = rd_data;
    endtask
    task automatic pulse_gate();
        gate_lvl <= 3'h1;
        cycles(4);
        gate_lvl <= 3'h0;
        cycles(4);
    endtask

    // watchdog against a hang
    initial begin
        cycles(100000);
        err_count++;
        finish_test();
    end

    // ==========================================================
    // main sequence
    initial begin
        cycles(8);
        sys_rst <= 1'b0;
        for (int a = 0; a < 8; a++) begin
            bus_rd(3'(a), v0);
            check({8'h00, v0 & ((a == 3) ? 8'hFB : 8'hFF)}, 16'h0000);
        end
        bus_wr(A_TC, 8'hFF);
        bus_rd(A_TC, v0);
        check({8'h00, v0}, 16'h00FD);
        clk_run <= 1'b1;
        // steady count rate per source, prescale and gate setting
        foreach (rows[i]) begin
            gate_lvl <= rows[i].lvl;
            bus_wr(A_GC, rows[i].gc);
            bus_wr(A_TC, rows[i].tc);
            cycles(16);
            bus_rd(A_LO, v0);
            cycles(62);
            bus_rd(A_LO, v1);
            check({8'h00, 8'(v1 - v0)}, {8'h00, rows[i].d});
        end
        clk_run <= 1'b0;
        gate_lvl <= 3'h0;
        bus_wr(A_GC, 8'h00);
        // rollover from all ones
        bus_wr(A_TC, 8'h00);
        bus_wr(A_FL, 8'h07);
        bus_wr(A_LO, 8'hFE);
        bus_wr(A_HI, 8'hFF);
        bus_wr(A_TC, 8'h41);
        cycles(8);
        #1 check({15'h0, overflow_flag}, 16'h0001);
        // enable low freezes the running counter: one step before, one after
        bus_rd(A_LO, v0);
        clk_en <= 1'b0;
        cycles(20);
        clk_en <= 1'b1;
        bus_rd(A_LO, v1);
        check({8'h00, 8'(v1 - v0)}, 16'h0002);
        // trigger clear of a stopped counter raises no overflow
        bus_wr(A_TC, 8'h00);
        bus_wr(A_FL, 8'h07);
        bus_wr(A_LO, 8'h34);
        bus_wr(A_HI, 8'h12);
        special_event_in <= 1'b1;
        cycles(1);
        special_event_in <= 1'b0;
        cycles(2);
        bus_rd(A_LO, v0);
        bus_rd(A_HI, v1);
        check({v1, v0}, 16'h0000);
        check({15'h0, overflow_flag}, 16'h0000);
        // byte write coincident with a trigger
        @(posedge sys_clk);
        bus_req <= '{A_LO, 8'h55, 1'b1, 1'b0};
        special_event_in <= 1'b1;
        @(posedge sys_clk);
        bus_req.wr <= 1'b0;
        special_event_in <= 1'b0;
        bus_rd(A_LO, v0);
        check({8'h00, v0}, 16'h0055);
        // capture of the whole count
        bus_wr(GST_ADDR_CCP_CONTROL, 8'h01);
        bus_wr(A_LO, 8'hCD);
        bus_wr(A_HI, 8'hAB);
        capture_event <= 1'b1;
        cycles(1);
        capture_event <= 1'b0;
        cycles(2);
        bus_rd(GST_ADDR_CCP_LOW, v0);
        bus_rd(GST_ADDR_CCP_HIGH, v1);
        check({v1, v0}, 16'hABCD);
        check({15'h0, ccp_flag}, 16'h0001);
        // compare pair as period of the counter
        bus_wr(GST_ADDR_CCP_LOW, 8'h08);
        bus_wr(GST_ADDR_CCP_HIGH, 8'h00);
        bus_wr(GST_ADDR_CCP_CONTROL, 8'h06);
        bus_wr(A_LO, 8'h00);
        bus_wr(A_HI, 8'h00);
        bus_wr(A_FL, 8'h07);
        // synchronized instruction clock while triggers are in use
        bus_wr(A_TC, 8'h01);
        found = 1'b0;
        for (int i = 0; i < 64 && !found; i++) begin
            @(posedge sys_clk);
            #1 found = (compare_event === 1'b1);
        end
        check({15'h0, found}, 16'h0001);
        if (!found) finish_test();
        cycles(200);
        bus_rd(A_HI, v1);
        bus_rd(A_LO, v0);
        check({v1, 7'h0, v0 <= 8'h08}, 16'h0001);
        check({15'h0, overflow_flag}, 16'h0000);
        bus_wr(A_TC, 8'h00);
        // gate value and gate event with gating off
        bus_wr(A_GC, 8'h40);
        gate_lvl <= 3'h1;
        cycles(4);
        bus_rd(A_GC, v0);
        check({15'h0, v0[2]}, 16'h0001);
        bus_wr(A_FL, 8'h07);
        gate_lvl <= 3'h0;
        cycles(4);
        #1 check({15'h0, gate_event_flag}, 16'h0001);
        // companion wrap as a gate pulse
        bus_wr(A_GC, 8'h41);
        bus_wr(A_FL, 8'h07);
        wrap_pulse <= 1'b1;
        cycles(1);
        wrap_pulse <= 1'b0;
        cycles(6);
        #1 check({15'h0, gate_event_flag}, 16'h0001);
        // single pulse: mode first, then go
        bus_wr(A_GC, 8'hD0);
        bus_wr(A_GC, 8'hD8);
        bus_rd(A_GC, v0);
        check({15'h0, v0[3]}, 16'h0001);
        pulse_gate();
        bus_rd(A_GC, v0);
        check({15'h0, v0[3]}, 16'h0000);
        bus_wr(A_TC, 8'h41);
        bus_rd(A_LO, v0);
        pulse_gate();
        bus_rd(A_LO, v1);
        check({v1, v0}, {v0, v0});
        // second power-on reset in mid-run
        sys_rst <= 1'b1;
        cycles(2);
        sys_rst <= 1'b0;
        bus_rd(A_TC, v0);
        check({8'h00, v0}, 16'h0000);
        finish_test();
    end
endmodule
